// *** ocp_compare.sv ***
// Functional notes
// RULE1: Control bit 3 picks timer A or B; timer A after reset.
// RULE2: Up to eight channels, each with its own mode control register.
// RULE3: Modes 001, 010, 011 drive low, drive high, toggle on match.
// RULE4: Single modes match when selected incrementing count equals main compare.
// RULE5: Timer wrapping before the main value leaves the pin unchanged.
// RULE6: Dual modes: main value first match, secondary value second match.
// RULE7: Mode 100 gives one pulse, mode 101 a continuous pulse train.
// RULE8: Another single pulse only after software writes mode 100 again.
// RULE9: Software sets timer period at or above secondary compare value.
// RULE10: Software loads compares and mode with timer stopped, then starts timer.
// RULE11: Modes 110, 111 are PWM; main becomes read-only latched duty.
// RULE12: Software writes period, duty, mode, then prescale and timer enable.
// RULE13: In mode 111 a low fault input tri-states the output.
// RULE14: Read-only fault status bit 4 shows a fault occurred.
// RULE15: Tri-state holds until fault gone and mode field rewritten.
// RULE16: PWM period is period value plus one timer increments.
// RULE17: At period wrap: clear timer, set pin, latch duty, flag timer.
// RULE18: Duty 0x0000 keeps the pin low at the period boundary.
// RULE19: Duty above period keeps the pin high all period.
// RULE20: In sleep the pin holds its level from before sleep.
// RULE21: After wake the channel resumes without reconfiguration.
// RULE22: Non-PWM compare events set a sticky flag cleared by software.
// RULE23: PWM modes never set the channel flag; timer event signals instead.
// RULE24: In idle runs only with bit 13 clear and timer running in idle.
// RULE25: PWM drives low at count equal to latched duty, high at wrap.
// RULE26: Dual modes go high on first match, low on second.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ocp_compare_regs.svh"

module ocp_compare #(
  parameter int unsigned CHANNELS = 8
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Time bases, same clock
  input wire ocp_pkg::ocp_timer_s TIMER_A,
  input wire ocp_pkg::ocp_timer_s TIMER_B,
  output logic [1:0] TIMER_PERIOD_EVENT,
  // Power state
  input wire logic IDLE,
  input wire logic SLEEP,
  // Pins
  input wire logic [1:0] FAULT_INPUT_PIN_N,
  output logic [CHANNELS-1:0] COMPARE_OUTPUT_PIN,
  output logic [CHANNELS-1:0] COMPARE_OUTPUT_OE
);

  // RULE2: eight channels at most
  if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
    $error("CHANNELS must lie between 1 and 8");
  end

  function automatic logic is_pwm(input ocp_pkg::ocp_mode_e m);
    return (m == ocp_pkg::OCP_MODE_PWM) || (m == ocp_pkg::OCP_MODE_PWMF);
  endfunction

  ocp_pkg::ocp_timer_s tmr [2];
  ocp_pkg::ocp_bus_e bus_st;
  logic [7:0] a_addr;
  logic a_write;
  logic [31:0] rd_word;
  logic wr_strobe;
  logic [2:0] wr_ch;
  logic [3:0] wr_reg;
  ocp_pkg::ocp_mode_e mode [CHANNELS];
  logic [CHANNELS-1:0] tsel;
  logic [CHANNELS-1:0] sidl;
  logic [CHANNELS-1:0] fault;
  logic [CHANNELS-1:0] armed;
  logic [CHANNELS-1:0] flag;
  logic [15:0] main_cmp [CHANNELS];
  logic [15:0] sec_cmp [CHANNELS];
  logic [CHANNELS-1:0] run;
  logic [CHANNELS-1:0] m1;
  logic [CHANNELS-1:0] m2;
  logic [CHANNELS-1:0] wrap;
  logic [CHANNELS-1:0] evt;
  logic [CHANNELS-1:0] flt_in;
  logic [CHANNELS-1:0] wr_ctl;
  logic [1:0] next_period_event;
  logic [1:0] f1;
  logic [1:0] f2;
  logic [1:0] f3;
  logic [1:0] flt_low;

  assign tmr[0] = TIMER_A;
  assign tmr[1] = TIMER_B;
  assign wr_strobe = (bus_st == ocp_pkg::OCP_BUS_DATA) && a_write && !a_addr[7];
  assign wr_ch = a_addr[6:4];
  assign wr_reg = a_addr[3:0];

  // Every transfer takes one wait state, so a write always lands before the next read samples.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      bus_st <= ocp_pkg::OCP_BUS_IDLE;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h0000_0000;
      a_addr <= 8'h00;
      a_write <= 1'b0;
    end else begin
      unique case (bus_st)
        ocp_pkg::OCP_BUS_IDLE: begin
          if (HSEL && HTRANS[1] && HREADY) begin
            bus_st <= ocp_pkg::OCP_BUS_DATA;
            HREADYOUT <= 1'b0;
            a_addr <= HADDR[7:0];
            a_write <= HWRITE;
          end
        end
        ocp_pkg::OCP_BUS_DATA: begin
          bus_st <= ocp_pkg::OCP_BUS_IDLE;
          HREADYOUT <= 1'b1;
          HRDATA <= a_write ? 32'h0000_0000 : rd_word;
        end
      endcase
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (a_addr == `OCP_FLAG_ADDR) begin
      rd_word[CHANNELS-1:0] = flag;
    end else if (!a_addr[7] && (32'(wr_ch) < CHANNELS)) begin
      unique case (wr_reg)
        `OCP_CTL_OFS: begin
          rd_word[`OCP_MODE_LSB +: 3] = mode[wr_ch];
          rd_word[`OCP_TSEL_BIT] = tsel[wr_ch];
          // RULE14: fault status visible
          rd_word[`OCP_FAULT_BIT] = fault[wr_ch];
          rd_word[`OCP_SIDL_BIT] = sidl[wr_ch];
        end
        `OCP_MAIN_OFS: rd_word[15:0] = main_cmp[wr_ch];
        `OCP_SEC_OFS: rd_word[15:0] = sec_cmp[wr_ch];
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // Fault pins are asynchronous; the filtered level moves only when stages two and three agree.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      f1 <= 2'b11;
      f2 <= 2'b11;
      f3 <= 2'b11;
      flt_low <= 2'b00;
    end else begin
      f1 <= FAULT_INPUT_PIN_N;
      f2 <= f1;
      f3 <= f2;
      for (int i = 0; i < 2; i++) begin
        if (f2[i] == f3[i]) begin
          flt_low[i] <= ~f3[i];
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      logic [15:0] cnt_next;
      logic t;
      cnt_next = 16'h0000;
      // RULE1: timebase selection
      t = tsel[c];
      // RULE16: wrap after count equals period, giving period plus one increments
      wrap[c] = tmr[t].tick && (tmr[t].timer_count == tmr[t].timer_period);
      // RULE5: a wrap yields count zero, never a jump past the compare value
      cnt_next = wrap[c] ? 16'h0000 : 16'(tmr[t].timer_count + 16'h0001);
      // RULE4: match on the increment that reaches the compare value
      m1[c] = tmr[t].tick && (cnt_next == main_cmp[c]);
      // RULE6: second match point from the secondary register
      m2[c] = tmr[t].tick && (cnt_next == sec_cmp[c]);
      // RULE24: idle gating; RULE20: sleep freezes the pin, single-pulse arming, duty latch and compare events
      run[c] = !SLEEP && !(IDLE && (sidl[c] || !tmr[t].timer_on || tmr[t].idle_stop));
      flt_in[c] = flt_low[(c >= CHANNELS / 2) ? 1 : 0];
      wr_ctl[c] = wr_strobe && (32'(wr_ch) == c) && (wr_reg == `OCP_CTL_OFS);
      // RULE22: compare events outside PWM
      // RULE23: PWM never raises the channel flag
      evt[c] = run[c] && !is_pwm(mode[c]) && (mode[c] != ocp_pkg::OCP_MODE_OFF) &&
               (m1[c] || (mode[c][2] && m2[c]));
    end
  end

  always_comb begin
    next_period_event = 2'b00;
    for (int c = 0; c < CHANNELS; c++) begin
      if (run[c] && is_pwm(mode[c]) && wrap[c]) begin
        next_period_event[tsel[c]] = 1'b1;
      end
    end
  end

  // RULE17: timer flag raised on the PWM period boundary
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      TIMER_PERIOD_EVENT <= 2'b00;
    end else begin
      TIMER_PERIOD_EVENT <= next_period_event;
    end
  end

  // RULE22: sticky flag, a new event beats a clear in the same cycle
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      flag <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (evt[c]) begin
          flag[c] <= 1'b1;
        end else if ((bus_st == ocp_pkg::OCP_BUS_DATA) && a_write &&
                     (a_addr == `OCP_FLAG_ADDR) && HWDATA[c]) begin
          flag[c] <= 1'b0;
        end
      end
    end
  end

  // Control and secondary compare registers, written by software.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int c = 0; c < CHANNELS; c++) begin
        mode[c] <= ocp_pkg::ocp_mode_e'(3'(`OCP_CTL_RESET));
        sec_cmp[c] <= `OCP_CMP_RESET;
      end
      tsel <= '0;
      sidl <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (wr_ctl[c]) begin
          mode[c] <= ocp_pkg::ocp_mode_e'(HWDATA[`OCP_MODE_LSB +: 3]);
          // RULE1: timebase select bit
          tsel[c] <= HWDATA[`OCP_TSEL_BIT];
          sidl[c] <= HWDATA[`OCP_SIDL_BIT];
        end
        if (wr_strobe && (32'(wr_ch) == c) && (wr_reg == `OCP_SEC_OFS)) begin
          sec_cmp[c] <= HWDATA[15:0];
        end
      end
    end
  end

  // Fault latch and pin enable.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      fault <= '0;
      COMPARE_OUTPUT_OE <= '1;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        // RULE13: low fault in mode 111 latches the fault
        if (!SLEEP && mode[c] == ocp_pkg::OCP_MODE_PWMF && flt_in[c]) begin
          fault[c] <= 1'b1;
        // RULE15: needs the fault gone and a rewrite of a PWM mode
        end else if (wr_ctl[c] && !flt_in[c] &&
                     is_pwm(ocp_pkg::ocp_mode_e'(HWDATA[`OCP_MODE_LSB +: 3]))) begin
          fault[c] <= 1'b0;
        end
        // RULE13: high impedance while the fault stands
        COMPARE_OUTPUT_OE[c] <= !fault[c];
      end
    end
  end

  // Pin, duty latch and single-pulse arming.
  // RULE21: nothing here resets on wake; state simply resumes.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      COMPARE_OUTPUT_PIN <= '0;
      armed <= '0;
      for (int c = 0; c < CHANNELS; c++) begin
        main_cmp[c] <= `OCP_CMP_RESET;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (run[c]) begin
          unique case (mode[c])
            ocp_pkg::OCP_MODE_OFF: COMPARE_OUTPUT_PIN[c] <= 1'b0;
            // RULE3: the three simple match actions
            ocp_pkg::OCP_MODE_LOW: if (m1[c]) COMPARE_OUTPUT_PIN[c] <= 1'b0;
            ocp_pkg::OCP_MODE_HIGH: if (m1[c]) COMPARE_OUTPUT_PIN[c] <= 1'b1;
            ocp_pkg::OCP_MODE_TOGGLE: if (m1[c]) COMPARE_OUTPUT_PIN[c] <= !COMPARE_OUTPUT_PIN[c];
            // RULE7: one pulse, then disarm
            ocp_pkg::OCP_MODE_SINGLE: begin
              if (armed[c] && m2[c]) begin
                COMPARE_OUTPUT_PIN[c] <= 1'b0;
                armed[c] <= 1'b0;
              end else if (armed[c] && m1[c]) begin
                COMPARE_OUTPUT_PIN[c] <= 1'b1;
              end
            end
            // RULE26: high on first match, low on second, every period
            ocp_pkg::OCP_MODE_CONT: begin
              if (m2[c]) begin
                COMPARE_OUTPUT_PIN[c] <= 1'b0;
              end else if (m1[c]) begin
                COMPARE_OUTPUT_PIN[c] <= 1'b1;
              end
            end
            ocp_pkg::OCP_MODE_PWM, ocp_pkg::OCP_MODE_PWMF: begin
              if (wrap[c]) begin
                // RULE11: duty moves to the active latch only at the boundary
                main_cmp[c] <= sec_cmp[c];
                // RULE18: zero duty never sets the pin
                COMPARE_OUTPUT_PIN[c] <= (sec_cmp[c] != `OCP_DUTY_ZERO);
              // RULE25: low when the count reaches the latched duty
              // RULE19: duty above period never matches, pin stays high
              end else if (m1[c]) begin
                COMPARE_OUTPUT_PIN[c] <= 1'b0;
              end
            end
          endcase
        end
        // RULE11: main register read-only in PWM modes
        if (wr_strobe && (32'(wr_ch) == c) && (wr_reg == `OCP_MAIN_OFS) && !is_pwm(mode[c])) begin
          main_cmp[c] <= HWDATA[15:0];
        end
        // RULE8: a write of mode 100 rearms the single pulse
        if (wr_ctl[c]) begin
          armed[c] <= (HWDATA[`OCP_MODE_LSB +: 3] == ocp_pkg::OCP_MODE_SINGLE);
        end
      end
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);

  tsel_write_a: assert property (wr_ctl[0] |=> tsel[0] == $past(HWDATA[`OCP_TSEL_BIT])) // RULE1
    else $error("timebase select not taken from control write");
  force_low_a: assert property (run[0] && mode[0] == ocp_pkg::OCP_MODE_LOW && m1[0] // RULE3
    |=> !COMPARE_OUTPUT_PIN[0]) else $error("force-low match left pin high");
  no_match_hold_a: assert property (run[0] && mode[0] != ocp_pkg::OCP_MODE_OFF && // RULE5
    !mode[0][2] && !m1[0] |=> $stable(COMPARE_OUTPUT_PIN[0]))
    else $error("simple mode pin moved without a match");
  main_ro_a: assert property (is_pwm(mode[0]) && !(run[0] && wrap[0]) // RULE11
    |=> $stable(main_cmp[0])) else $error("PWM duty latch changed off boundary");
  fault_tristate_a: assert property (!SLEEP && mode[0] == ocp_pkg::OCP_MODE_PWMF && // RULE13
    flt_in[0] |-> ##[1:2] !COMPARE_OUTPUT_OE[0]) else $error("fault did not tri-state");
  fault_hold_a: assert property (fault[0] && flt_in[0] |=> fault[0]) // RULE15
    else $error("fault released while fault input still low");
  duty_latch_a: assert property (run[0] && is_pwm(mode[0]) && wrap[0] // RULE17
    |=> main_cmp[0] == $past(sec_cmp[0]) && TIMER_PERIOD_EVENT[$past(tsel[0])])
    else $error("period boundary missed duty latch or timer event");
  zero_duty_a: assert property (run[0] && is_pwm(mode[0]) && wrap[0] && // RULE18
    sec_cmp[0] == `OCP_DUTY_ZERO |=> !COMPARE_OUTPUT_PIN[0]) else $error("zero duty set pin");
  sleep_hold_a: assert property (SLEEP |=> $stable(COMPARE_OUTPUT_PIN)) // RULE20
    else $error("pin changed during sleep");
  flag_set_a: assert property (evt[0] |=> flag[0]) // RULE22
    else $error("compare event did not set channel flag");
  pwm_no_flag_a: assert property (is_pwm(mode[0]) && !flag[0] |=> !flag[0]) // RULE23
    else $error("channel flag set in PWM mode");

  single_pulse_c: cover property (mode[0] == ocp_pkg::OCP_MODE_SINGLE && armed[0] && m2[0]);
  pwm_wrap_c: cover property (run[0] && is_pwm(mode[0]) && wrap[0] && sec_cmp[0] != 16'h0000);
  fault_seen_c: cover property (fault[0] ##1 !fault[0]);

endmodule // ocp_compare

// *** ocp_compare_regs.svh ***
`ifndef OCP_COMPARE_REGS_SVH
`define OCP_COMPARE_REGS_SVH

// Byte offsets inside one channel's 16-byte slot.
`define OCP_CTL_OFS 4'h0
`define OCP_MAIN_OFS 4'h4
`define OCP_SEC_OFS 4'h8
// Channel interrupt flag register, one bit per channel, write one to clear.
`define OCP_FLAG_ADDR 8'h80

// Control register field positions.
`define OCP_MODE_LSB 0
`define OCP_TSEL_BIT 3
`define OCP_FAULT_BIT 4
`define OCP_SIDL_BIT 13

// Reset values.
`define OCP_CTL_RESET 16'h0000
`define OCP_CMP_RESET 16'h0000
`define OCP_DUTY_ZERO 16'h0000

`endif

// *** ocp_load_model.sv ***
`timescale 1ns/1ps

module ocp_load_model (
  // Driven pin
  input wire logic pin,
  input wire logic oe,
  // Fault source
  input wire logic fault_cmd,
  // Observed side
  output logic level,
  output logic fault_n
);
  // The load pulls a released pin low, so a stale high never reads back.
  assign level = oe ? pin : 1'b0;
  assign fault_n = ~fault_cmd;
endmodule // ocp_load_model

// *** ocp_pkg.sv ***
package ocp_pkg;

  typedef enum logic [2:0] {
    OCP_MODE_OFF    = 3'b000,
    OCP_MODE_LOW    = 3'b001,
    OCP_MODE_HIGH   = 3'b010,
    OCP_MODE_TOGGLE = 3'b011,
    OCP_MODE_SINGLE = 3'b100,
    OCP_MODE_CONT   = 3'b101,
    OCP_MODE_PWM    = 3'b110,
    OCP_MODE_PWMF   = 3'b111
  } ocp_mode_e;

  typedef enum logic [1:0] {
    OCP_BUS_IDLE = 2'b01,
    OCP_BUS_DATA = 2'b10
  } ocp_bus_e;

  // One time base as the channels see it.
  typedef struct packed {
    logic [15:0] timer_count;
    logic [15:0] timer_period;
    logic tick;
    logic timer_on;
    logic idle_stop;
  } ocp_timer_s;

endpackage

// *** test_output_compare_pwm_channel.sv ***
`timescale 1ns/1ps
`include "ocp_compare_regs.svh"

module test_output_compare_pwm_channel;
  localparam logic [7:0] ctl_a = {4'h0, `OCP_CTL_OFS};
  localparam logic [7:0] main_a = {4'h0, `OCP_MAIN_OFS};
  localparam logic [7:0] sec_a = {4'h0, `OCP_SEC_OFS};
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic idle = 1'b0;
  logic sleep = 1'b0;
  logic fault_cmd = 1'b0;
  logic fault_n;
  logic level;
  logic [1:0] period_event;
  logic [7:0] pins;
  logic [7:0] oes;
  logic [15:0] t_cnt [2] = '{16'h0000, 16'h0000};
  logic [15:0] t_per [2] = '{16'h0000, 16'h0000};
  logic t_on [2] = '{1'b0, 1'b0};
  ocp_pkg::ocp_timer_s timer_a;
  ocp_pkg::ocp_timer_s timer_b;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #4 mclk = ~mclk;

  assign timer_a = '{t_cnt[0], t_per[0], t_on[0], t_on[0], 1'b0};
  assign timer_b = '{t_cnt[1], t_per[1], t_on[1], t_on[1], 1'b0};

  always @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (t_on[i]) begin
        t_cnt[i] <= (t_cnt[i] == t_per[i]) ? 16'h0000 : t_cnt[i] + 16'h0001;
      end
    end
  end

  ocp_compare dut (.MCLK(mclk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hreadyout), .HWDATA(hwdata),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .TIMER_A(timer_a),
    .TIMER_B(timer_b), .TIMER_PERIOD_EVENT(period_event), .IDLE(idle), .SLEEP(sleep),
    .FAULT_INPUT_PIN_N({1'b1, fault_n}), .COMPARE_OUTPUT_PIN(pins),
    .COMPARE_OUTPUT_OE(oes));

  ocp_load_model load (.pin(pins[0]), .oe(oes[0]), .fault_cmd(fault_cmd), .level(level),
    .fault_n(fault_n));

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hung handshake ends here instead of running forever.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] wd,
                      output logic [15:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata[15:0];
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] unused;
    xfer(1'b1, a, d, unused);
  endtask

  task automatic timer(input int i, input logic on, input logic [15:0] per);
    @(posedge mclk);
    t_on[i] <= on;
    t_per[i] <= per;
    if (!on) begin
      @(posedge mclk);
      t_cnt[i] <= 16'h0000;
    end
  endtask

  task automatic start(input ocp_pkg::ocp_mode_e m, input logic [15:0] mv, sv, per);
    timer(0, 1'b0, per);
    wr(main_a, mv);
    wr(sec_a, sv);
    wr(ctl_a, 16'(m));
    timer(0, 1'b1, per);
  endtask

  task automatic watch(input int n, output int hi, output int ev);
    hi = 0;
    ev = 0;
    repeat (n) begin
      @(posedge mclk);
      if (level === 1'b1) hi++;
      if (period_event[0] === 1'b1) ev++;
    end
  endtask

  task automatic t_reset();
    logic [15:0] r;
    xfer(1'b0, ctl_a, 16'h0000, r);
    chk(r === `OCP_CTL_RESET, "control not reset, timer A not chosen");
    chk(hresp === 1'b0, "error response on register bus");
    xfer(1'b0, sec_a, 16'h0000, r);
    chk(r === `OCP_CMP_RESET, "secondary compare not reset");
    wr(8'h0C, 16'hFFFF);
    xfer(1'b0, 8'h0C, 16'h0000, r);
    chk(r === 16'h0000, "unmapped word not zero");
  endtask

  task automatic t_simple();
    start(ocp_pkg::OCP_MODE_HIGH, 16'h001E, 16'h0000, 16'h0014);
    repeat (45) @(posedge mclk);
    chk(level === 1'b0, "pin moved with compare beyond period");
    wr(main_a, 16'h0005);
    repeat (25) @(posedge mclk);
    chk(level === 1'b1, "force high missing");
    wr(ctl_a, 16'(ocp_pkg::OCP_MODE_LOW));
    repeat (25) @(posedge mclk);
    chk(level === 1'b0, "force low missing");
    timer(0, 1'b0, 16'h0014);
    timer(1, 1'b0, 16'h0014);
    wr(ctl_a, 16'h0008 | 16'(ocp_pkg::OCP_MODE_TOGGLE));
    timer(1, 1'b1, 16'h0014);
    repeat (12) @(posedge mclk);
    chk(level === 1'b1, "toggle on timer B missing");
    repeat (21) @(posedge mclk);
    chk(level === 1'b0, "second toggle missing");
    timer(1, 1'b0, 16'h0014);
  endtask

  task automatic t_pulse();
    int hi;
    int ev;
    logic [15:0] r;
    logic lv;
    start(ocp_pkg::OCP_MODE_SINGLE, 16'h0004, 16'h0008, 16'h000C);
    watch(39, hi, ev);
    chk(hi == 4, "single pulse width wrong");
    // Matches keep raising the flag while the timer runs, so it is stopped first.
    timer(0, 1'b0, 16'h000C);
    xfer(1'b0, `OCP_FLAG_ADDR, 16'h0000, r);
    chk(r[0] === 1'b1, "compare flag not set");
    wr(`OCP_FLAG_ADDR, 16'h0001);
    xfer(1'b0, `OCP_FLAG_ADDR, 16'h0000, r);
    chk(r[0] === 1'b0, "compare flag not cleared");
    wr(ctl_a, 16'(ocp_pkg::OCP_MODE_SINGLE));
    timer(0, 1'b1, 16'h000C);
    watch(39, hi, ev);
    chk(hi == 4, "rearmed pulse wrong");
    start(ocp_pkg::OCP_MODE_CONT, 16'h0004, 16'h0008, 16'h000C);
    watch(39, hi, ev);
    chk(hi == 12, "pulse train wrong");
    while (level !== 1'b1) @(posedge mclk);
    sleep <= 1'b1;
    @(posedge mclk);
    lv = level;
    watch(30, hi, ev);
    chk(hi == (lv ? 30 : 0), "pin moved in sleep");
    sleep <= 1'b0;
    repeat (13) @(posedge mclk);
    watch(39, hi, ev);
    chk(hi == 12, "train not resumed after wake");
  endtask

  task automatic t_pwm();
    int hi;
    int ev;
    logic [15:0] r;
    start(ocp_pkg::OCP_MODE_PWM, 16'h0000, 16'h0003, 16'h0009);
    // In PWM no compare event can set the flag again behind the clear.
    wr(`OCP_FLAG_ADDR, 16'h00FF);
    repeat (10) @(posedge mclk);
    watch(20, hi, ev);
    chk(hi == 6, "duty high time wrong");
    chk(ev == 2, "period events per two periods wrong");
    wr(main_a, 16'h0007);
    xfer(1'b0, main_a, 16'h0000, r);
    chk(r === 16'h0003, "active duty latch writable");
    wr(sec_a, `OCP_DUTY_ZERO);
    repeat (20) @(posedge mclk);
    watch(20, hi, ev);
    chk(hi == 0, "zero duty pin high");
    wr(sec_a, 16'h000F);
    repeat (20) @(posedge mclk);
    watch(20, hi, ev);
    chk(hi == 20, "over-period duty pin low");
    xfer(1'b0, `OCP_FLAG_ADDR, 16'h0000, r);
    chk(r[0] === 1'b0, "compare flag set in pwm");
  endtask

  task automatic t_fault();
    logic [15:0] r;
    wr(ctl_a, 16'(ocp_pkg::OCP_MODE_PWMF));
    fault_cmd <= 1'b1;
    repeat (8) @(posedge mclk);
    chk(oes[0] === 1'b0, "fault did not release pin");
    xfer(1'b0, ctl_a, 16'h0000, r);
    chk(r[`OCP_FAULT_BIT] === 1'b1, "fault status not set");
    fault_cmd <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(oes[0] === 1'b0, "pin driven before mode rewrite");
    wr(ctl_a, 16'(ocp_pkg::OCP_MODE_PWMF));
    repeat (3) @(posedge mclk);
    chk(oes[0] === 1'b1, "pin not driven after rewrite");
    chk(oes[7:1] === 7'h7F, "unused channel released its pin");
    chk(pins[7:1] === 7'h00, "unused channel pin moved");
  endtask

  task automatic t_idle();
    int hi;
    int ev;
    idle <= 1'b1;
    repeat (13) @(posedge mclk);
    watch(39, hi, ev);
    chk(hi == 12, "channel stopped in idle with stop bit clear");
    idle <= 1'b0;
    wr(ctl_a, 16'h2000 | 16'(ocp_pkg::OCP_MODE_CONT));
    // Wait for a fresh rising level so no falling match shares the idle edge.
    while (level !== 1'b0) @(posedge mclk);
    while (level !== 1'b1) @(posedge mclk);
    idle <= 1'b1;
    watch(30, hi, ev);
    chk(hi == 30, "channel ran in idle with stop bit set");
    idle <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_simple();
    t_pulse();
    t_idle();
    t_pwm();
    t_fault();
    results();
  end
endmodule // test_output_compare_pwm_channel
